/* verilog/apll_regs.svh */
`ifndef APLL_REGS_SVH
`define APLL_REGS_SVH

// byte offsets on the serial management port
`define APLL_OFS_LOOP_FILTER 8'h68
`define APLL_OFS_LOCK_MODE 8'h69
`define APLL_OFS_MANUAL_VCO 8'h6A
`define APLL_OFS_RESERVED 8'h6B

// loop filter register fields
`define APLL_PUMP_MSB 7
`define APLL_PUMP_LSB 5
`define APLL_RES_MSB 4
`define APLL_RES_LSB 3
`define APLL_CAP_MSB 2
`define APLL_CAP_LSB 1
`define APLL_POLE_BIT 0

// lock mode register fields
`define APLL_TDC_OFF_BIT 4
`define APLL_SYNTH_BIT 3
`define APLL_CNT_WIDTH_BIT 1
`define APLL_OVERRIDE_BIT 0

// manual oscillator register fields
`define APLL_VCO_MSB 7
`define APLL_VCO_LSB 5
`define APLL_LOCKVAL_MSB 4
`define APLL_LOCKVAL_LSB 0

// reset values
`define APLL_RST_PUMP 3'h7
`define APLL_RST_RES 2'h1
`define APLL_RST_CAP 2'h3
`define APLL_RST_POLE 1'h0
`define APLL_RST_TDC_OFF 1'h0
`define APLL_RST_SYNTH 1'h0
`define APLL_RST_CNT_WIDTH 1'h1
`define APLL_RST_OVERRIDE 1'h0
`define APLL_RST_VCO 3'h1
`define APLL_RST_LOCKVAL 5'h0B

// oscillator codes at or above this are reserved
`define APLL_VCO_FIRST_RSVD 3'h6
// accumulator widths chosen by the lock count bit
`define APLL_CNT_BITS_WIDE 5'h14
`define APLL_CNT_BITS_NARROW 5'h10

`endif

/* verilog/apll_pkg.sv */
package apll_pkg;
  typedef logic [7:0] apll_byte_t;
  typedef logic [2:0] apll_vco_t;
  typedef logic [4:0] apll_lockval_t;

  typedef struct packed {
    logic [2:0] pump_current_sel;
    logic [1:0] filter_series_res_sel;
    logic [1:0] filter_parallel_cap_sel;
    logic second_pole_sel;
    logic time_converter_off;
    logic crystal_only_synth;
    logic lock_counter_width;
    logic lock_manual_override;
    apll_vco_t manual_oscillator_sel;
    apll_lockval_t manual_lock_value;
  } apll_fields_t;

  typedef struct packed {
    apll_fields_t f;
    apll_byte_t rd_data;
    logic rd_valid;
    apll_vco_t vco_sel;
    apll_lockval_t lock_value;
    logic vco_code_rsvd;
    logic [4:0] lock_count_bits;
  } apll_state_t;
endpackage : apll_pkg

/* verilog/apll_lock_if.sv */
`timescale 1ns/100ps
interface apll_lock_if;
  logic override;
  logic width_sel;
  apll_pkg::apll_vco_t manual_vco;
  apll_pkg::apll_lockval_t manual_value;
  apll_pkg::apll_vco_t auto_vco;
  apll_pkg::apll_lockval_t auto_value;
  apll_pkg::apll_vco_t eff_vco;
  apll_pkg::apll_lockval_t eff_value;
  logic vco_rsvd;
  logic [4:0] count_bits;

  modport bank (
    output override, width_sel, manual_vco, manual_value, auto_vco, auto_value,
    input eff_vco, eff_value, vco_rsvd, count_bits
  );
  modport sel (
    input override, width_sel, manual_vco, manual_value, auto_vco, auto_value,
    output eff_vco, eff_value, vco_rsvd, count_bits
  );
endinterface : apll_lock_if

/* verilog/apll_lock_sel.sv */
`timescale 1ns/100ps
`include "apll_regs.svh"
module apll_lock_sel (
  apll_lock_if.sel lk // lock control values in, applied values out
);
  import apll_pkg::*;

  always_comb begin
    if (lk.override) begin
      lk.eff_vco = lk.manual_vco;
      lk.eff_value = lk.manual_value;
      lk.vco_rsvd = (lk.manual_vco >= `APLL_VCO_FIRST_RSVD);
    end else begin
      lk.eff_vco = lk.auto_vco;
      lk.eff_value = lk.auto_value;
      lk.vco_rsvd = 1'b0;
    end
    lk.count_bits = lk.width_sel ? `APLL_CNT_BITS_NARROW : `APLL_CNT_BITS_WIDE;
  end
endmodule : apll_lock_sel

/* verilog/apll_ctrl_regs.sv */
`timescale 1ns/100ps
`include "apll_regs.svh"
module apll_ctrl_regs #(
  parameter int ADDR_W = 8
) (
  input wire logic clk, // 50 MHz register clock
  input wire logic rst_b, // synchronous reset, active low
  input wire logic [ADDR_W-1:0] reg_addr, // register byte address
  input wire logic reg_wr, // write strobe, one cycle
  input wire apll_pkg::apll_byte_t reg_wdata, // write data
  input wire logic reg_rd, // read strobe, one cycle
  output logic [7:0] reg_rdata, // read data, valid with reg_rvalid
  output logic reg_rvalid, // read data valid pulse
  input wire apll_pkg::apll_vco_t auto_vco_sel, // oscillator chosen by calibration
  input wire apll_pkg::apll_lockval_t auto_lock_value, // lock value chosen by calibration
  output logic [2:0] pump_current_sel, // charge pump current code
  output logic [1:0] filter_series_res_sel, // loop filter series resistor code
  output logic [1:0] filter_parallel_cap_sel, // loop filter parallel capacitor code
  output logic second_pole_sel, // high post resistance when set
  output logic time_converter_off, // converter disabled when set
  output logic crystal_only_synth, // crystal-only synthesis when set
  output logic lock_manual_override, // manual lock mode when set
  output logic [2:0] vco_sel, // oscillator in use
  output logic [4:0] lock_value, // lock control value in use
  output logic vco_code_rsvd, // manual mode is using a reserved oscillator code
  output logic [4:0] lock_count_bits // lock accumulator width in bits
);
  import apll_pkg::*;

  generate
    if (ADDR_W < 7) begin : g_bad_addr
      $error("apll_ctrl_regs: ADDR_W too small for the register offsets");
    end

    // the header places the fields and the package sizes them; the two must agree
    if (`APLL_PUMP_MSB - `APLL_PUMP_LSB != 2) begin : g_bad_pump
      $error("apll_ctrl_regs: pump field position does not match its width");
    end

    if (`APLL_RES_MSB - `APLL_RES_LSB != 1) begin : g_bad_res
      $error("apll_ctrl_regs: resistor field position does not match its width");
    end

    if (`APLL_CAP_MSB - `APLL_CAP_LSB != 1) begin : g_bad_cap
      $error("apll_ctrl_regs: capacitor field position does not match its width");
    end

    if (`APLL_VCO_MSB - `APLL_VCO_LSB != 2) begin : g_bad_vco
      $error("apll_ctrl_regs: oscillator field position does not match its width");
    end

    if (`APLL_LOCKVAL_MSB - `APLL_LOCKVAL_LSB != 4) begin : g_bad_lockval
      $error("apll_ctrl_regs: lock value field position does not match its width");
    end

    if (`APLL_PUMP_MSB > 7 || `APLL_RES_MSB > 7 || `APLL_CAP_MSB > 7 || `APLL_POLE_BIT > 7 ||
        `APLL_TDC_OFF_BIT > 7 || `APLL_SYNTH_BIT > 7 || `APLL_CNT_WIDTH_BIT > 7 ||
        `APLL_OVERRIDE_BIT > 7 || `APLL_VCO_MSB > 7 || `APLL_LOCKVAL_MSB > 7) begin : g_bad_pos
      $error("apll_ctrl_regs: a field lies outside the register byte");
    end

    // a reserved code out of reset would raise the flag as soon as the host selects manual mode
    if (`APLL_RST_VCO >= `APLL_VCO_FIRST_RSVD) begin : g_bad_rst_vco
      $error("apll_ctrl_regs: oscillator reset code falls in the reserved range");
    end
  endgenerate

  apll_state_t s_q;
  apll_state_t s_d;
  apll_fields_t rst_f;
  apll_lock_if lk ();

  logic [7:0] addr8;
  logic addr_upper_clear;

  // only the low byte is decoded, so a set bit above it must steer away from this page
  generate
    if (ADDR_W > 8) begin : g_wide_addr
      assign addr_upper_clear = (reg_addr[ADDR_W-1:8] == '0);
    end else begin : g_byte_addr
      assign addr_upper_clear = 1'b1;
    end
  endgenerate
  // address 8'h00 is unmapped: writes to it are dropped and reads return zero
  assign addr8 = addr_upper_clear ? 8'(reg_addr) : 8'h00;

  always_comb begin
    rst_f.pump_current_sel = `APLL_RST_PUMP;
    rst_f.filter_series_res_sel = `APLL_RST_RES;
    rst_f.filter_parallel_cap_sel = `APLL_RST_CAP;
    rst_f.second_pole_sel = `APLL_RST_POLE;
    rst_f.time_converter_off = `APLL_RST_TDC_OFF;
    rst_f.crystal_only_synth = `APLL_RST_SYNTH;
    rst_f.lock_counter_width = `APLL_RST_CNT_WIDTH;
    rst_f.lock_manual_override = `APLL_RST_OVERRIDE;
    rst_f.manual_oscillator_sel = `APLL_RST_VCO;
    rst_f.manual_lock_value = `APLL_RST_LOCKVAL;
  end

  // field values feed the selector straight from the flops, so its result lands a cycle later
  assign lk.override = s_q.f.lock_manual_override;
  assign lk.width_sel = s_q.f.lock_counter_width;
  assign lk.manual_vco = s_q.f.manual_oscillator_sel;
  assign lk.manual_value = s_q.f.manual_lock_value;
  assign lk.auto_vco = auto_vco_sel;
  assign lk.auto_value = auto_lock_value;

  apll_lock_sel u_lock_sel (
    .lk(lk.sel)
  );

  // read-back images use the same field positions as the write decode
  apll_byte_t img_loop;
  apll_byte_t img_mode;
  apll_byte_t img_vco;

  always_comb begin
    img_loop = 8'h00;
    img_loop[`APLL_PUMP_MSB:`APLL_PUMP_LSB] = s_q.f.pump_current_sel;
    img_loop[`APLL_RES_MSB:`APLL_RES_LSB] = s_q.f.filter_series_res_sel;
    img_loop[`APLL_CAP_MSB:`APLL_CAP_LSB] = s_q.f.filter_parallel_cap_sel;
    img_loop[`APLL_POLE_BIT] = s_q.f.second_pole_sel;
  end

  always_comb begin
    // reserved positions of the mode byte are not stored and read as zero
    img_mode = 8'h00;
    img_mode[`APLL_TDC_OFF_BIT] = s_q.f.time_converter_off;
    img_mode[`APLL_SYNTH_BIT] = s_q.f.crystal_only_synth;
    img_mode[`APLL_CNT_WIDTH_BIT] = s_q.f.lock_counter_width;
    img_mode[`APLL_OVERRIDE_BIT] = s_q.f.lock_manual_override;
  end

  always_comb begin
    // reserved oscillator codes read back exactly as written
    img_vco = 8'h00;
    img_vco[`APLL_VCO_MSB:`APLL_VCO_LSB] = s_q.f.manual_oscillator_sel;
    img_vco[`APLL_LOCKVAL_MSB:`APLL_LOCKVAL_LSB] = s_q.f.manual_lock_value;
  end

  always_comb begin
    s_d = s_q;
    s_d.rd_valid = 1'b0;
    if (reg_wr) begin
      if (addr8 == `APLL_OFS_LOOP_FILTER) begin
        s_d.f.pump_current_sel = reg_wdata[`APLL_PUMP_MSB:`APLL_PUMP_LSB];
        s_d.f.filter_series_res_sel = reg_wdata[`APLL_RES_MSB:`APLL_RES_LSB];
        s_d.f.filter_parallel_cap_sel = reg_wdata[`APLL_CAP_MSB:`APLL_CAP_LSB];
        s_d.f.second_pole_sel = reg_wdata[`APLL_POLE_BIT];
      end else if (addr8 == `APLL_OFS_LOCK_MODE) begin
        // reserved positions are not stored; the host is expected to write them as zero
        s_d.f.time_converter_off = reg_wdata[`APLL_TDC_OFF_BIT];
        s_d.f.crystal_only_synth = reg_wdata[`APLL_SYNTH_BIT];
        s_d.f.lock_counter_width = reg_wdata[`APLL_CNT_WIDTH_BIT];
        s_d.f.lock_manual_override = reg_wdata[`APLL_OVERRIDE_BIT];
      end else if (addr8 == `APLL_OFS_MANUAL_VCO) begin
        // reserved oscillator codes are kept as written and flagged while in manual mode, not clamped
        s_d.f.manual_oscillator_sel = reg_wdata[`APLL_VCO_MSB:`APLL_VCO_LSB];
        s_d.f.manual_lock_value = reg_wdata[`APLL_LOCKVAL_MSB:`APLL_LOCKVAL_LSB];
      end
    end
    if (reg_rd) begin
      s_d.rd_valid = 1'b1;
      s_d.rd_data = 8'h00;
      if (addr8 == `APLL_OFS_LOOP_FILTER) begin
        s_d.rd_data = img_loop;
      end else if (addr8 == `APLL_OFS_LOCK_MODE) begin
        s_d.rd_data = img_mode;
      end else if (addr8 == `APLL_OFS_MANUAL_VCO) begin
        s_d.rd_data = img_vco;
      end else if (addr8 == `APLL_OFS_RESERVED) begin
        // the whole byte is reserved; zero is returned rather than anything undefined
        s_d.rd_data = 8'h00;
      end
    end
    s_d.vco_sel = lk.eff_vco;
    s_d.lock_value = lk.eff_value;
    s_d.vco_code_rsvd = lk.vco_rsvd;
    s_d.lock_count_bits = lk.count_bits;
    if (!rst_b) begin
      s_d.f = rst_f;
      s_d.rd_data = 8'h00;
      s_d.rd_valid = 1'b0;
      s_d.vco_sel = auto_vco_sel;
      s_d.lock_value = auto_lock_value;
      s_d.vco_code_rsvd = 1'b0;
      s_d.lock_count_bits = `APLL_RST_CNT_WIDTH ? `APLL_CNT_BITS_NARROW : `APLL_CNT_BITS_WIDE;
    end
  end

  always_ff @(posedge clk) begin
    s_q <= s_d;
  end

  assign reg_rdata = s_q.rd_data;
  assign reg_rvalid = s_q.rd_valid;
  assign pump_current_sel = s_q.f.pump_current_sel;
  assign filter_series_res_sel = s_q.f.filter_series_res_sel;
  assign filter_parallel_cap_sel = s_q.f.filter_parallel_cap_sel;
  assign second_pole_sel = s_q.f.second_pole_sel;
  assign time_converter_off = s_q.f.time_converter_off;
  assign crystal_only_synth = s_q.f.crystal_only_synth;
  assign lock_manual_override = s_q.f.lock_manual_override;
  assign vco_sel = s_q.vco_sel;
  assign lock_value = s_q.lock_value;
  assign vco_code_rsvd = s_q.vco_code_rsvd;
  assign lock_count_bits = s_q.lock_count_bits;
endmodule : apll_ctrl_regs

/* tb/apll_ctrl_sva.sv */
`timescale 1ns/100ps
module apll_ctrl_sva #(
  parameter int ADDR_W = 8
) (
  input wire logic clk, // clock
  input wire logic rst_b, // reset
  input wire logic [ADDR_W-1:0] reg_addr, // address
  input wire logic reg_wr, // write
  input wire apll_pkg::apll_byte_t reg_wdata, // data
  input wire logic reg_rd, // read
  input wire logic [7:0] reg_rdata, // answer
  input wire logic reg_rvalid, // valid
  input wire apll_pkg::apll_vco_t auto_vco_sel, // auto code
  input wire apll_pkg::apll_lockval_t auto_lock_value, // auto value
  input wire logic [2:0] pump_current_sel, // field
  input wire logic lock_manual_override, // field
  input wire logic [2:0] vco_sel, // applied
  input wire logic [4:0] lock_value, // applied
  input wire logic vco_code_rsvd, // flag
  input wire logic [4:0] lock_count_bits // width
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence wr_at(a);
    reg_wr && reg_addr == a;
  endsequence
  chk_reset_dflt: assert property ($rose(rst_b) |-> pump_current_sel == 3'h7
    && !lock_manual_override && lock_count_bits == 5'h10) else $error("bad defaults");
  chk_pump_load: assert property (wr_at(8'h68) |=>
    pump_current_sel == $past(reg_wdata[7:5])) else $error("pump code not loaded");
  chk_mode_load: assert property (wr_at(8'h69) |=>
    lock_manual_override == $past(reg_wdata[0])) else $error("override not loaded");
  chk_count_width: assert property (wr_at(8'h69) |-> ##2
    lock_count_bits == ($past(reg_wdata[1], 2) ? 5'h10 : 5'h14)) else $error("bad width");
  chk_auto_follow: assert property (!lock_manual_override |=> vco_sel == $past(auto_vco_sel)
    && lock_value == $past(auto_lock_value) && !vco_code_rsvd) else $error("auto not applied");
  chk_manual_apply: assert property (wr_at(8'h6A) ##0 lock_manual_override
    ##1 lock_manual_override |=> vco_sel == $past(reg_wdata[7:5], 2)
    && lock_value == $past(reg_wdata[4:0], 2)
    && vco_code_rsvd == ($past(reg_wdata[7:6], 2) == 2'h3)) else $error("manual not applied");
  chk_rsvd_read: assert property (reg_rd && reg_addr == 8'h6B |=> reg_rvalid
    && reg_rdata == 8'h00) else $error("reserved byte not zero");
  chk_mode_rdback: assert property (reg_rd && reg_addr == 8'h69 |=> reg_rvalid
    && (reg_rdata & 8'hE4) == 8'h00) else $error("reserved bits not zero");
endmodule : apll_ctrl_sva
bind apll_ctrl_regs apll_ctrl_sva #(.ADDR_W(ADDR_W)) u_sva (.clk(clk), .rst_b(rst_b),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .auto_vco_sel(auto_vco_sel),
  .auto_lock_value(auto_lock_value), .pump_current_sel(pump_current_sel),
  .lock_manual_override(lock_manual_override), .vco_sel(vco_sel), .lock_value(lock_value),
  .vco_code_rsvd(vco_code_rsvd), .lock_count_bits(lock_count_bits));

/* tb/apll_host_model.sv */
`timescale 1ns/100ps
module apll_host_model (
  input wire logic clk, // clock
  output logic [7:0] reg_addr, // address
  output logic reg_wr, // write strobe
  output logic [7:0] reg_wdata, // write data
  output logic reg_rd, // read strobe
  input wire logic [7:0] reg_rdata, // read data
  input wire logic reg_rvalid // read valid
);
  initial {reg_addr, reg_wr, reg_wdata, reg_rd} = 18'h0;
  task automatic put(logic [7:0] a, logic [7:0] d, logic w);
    @(posedge clk) #1;
    {reg_addr, reg_wdata, reg_wr, reg_rd} = {a, d, w, !w};
    @(posedge clk) #1;
    // released bus shows the inverse so a late sample cannot match by luck
    {reg_addr, reg_wdata, reg_wr, reg_rd} = {~a, ~d, 2'h0};
  endtask : put
  task automatic wr(logic [7:0] a, logic [7:0] d);
    // free-run forcing for crystal-only mode lives in the digital loop bank
    put(a, a == 8'h69 ? d & 8'h1B : (a == 8'h6B ? 8'h00 : d), 1'b1);
  endtask : wr
  task automatic rd(logic [7:0] a, output logic [7:0] d);
    put(a, 8'h00, 1'b0);
    for (int n = 0; n < 4 && reg_rvalid !== 1'b1; n++) @(posedge clk) #1;
    if (reg_rvalid !== 1'b1) begin
      tb.failures++;
      tb.report_and_stop();
    end else begin
      d = reg_rdata;
    end
  endtask : rd
endmodule : apll_host_model

/* tb/tb.sv */
`timescale 1ns/100ps
module tb;
  import apll_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, got;
  logic reg_wr, reg_rd, reg_rvalid, pole, tdc, syn, ovr, rsvd;
  apll_vco_t auto_vco_sel = 3'h0, vco_sel;
  apll_lockval_t auto_lock_value = 5'h00, lock_value;
  logic [2:0] pump;
  logic [1:0] res, cap;
  logic [4:0] cnt;
  logic [8:0] e;
  logic [7:0] x;
  int failures = 0, cmp_count = 0;
  int rf[4];
  always #10 clk = ~clk;
  apll_host_model host (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
  apll_ctrl_regs dut (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .auto_vco_sel(auto_vco_sel), .auto_lock_value(auto_lock_value), .pump_current_sel(pump),
    .filter_series_res_sel(res), .filter_parallel_cap_sel(cap), .second_pole_sel(pole),
    .time_converter_off(tdc), .crystal_only_synth(syn), .lock_manual_override(ovr),
    .vco_sel(vco_sel), .lock_value(lock_value), .vco_code_rsvd(rsvd), .lock_count_bits(cnt));
  task report_and_stop();
    if (failures == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : report_and_stop
  task chk_pins(logic [31:0] g, logic [31:0] x);
    cmp_count++;
    if (g !== x) begin
      failures++;
      $display("MISMATCH %0t got %h exp %h", $time, g, x);
    end
  endtask : chk_pins
  task chk_byte(logic [7:0] g, logic [7:0] x);
    chk_pins({24'h0, g}, {24'h0, x});
  endtask : chk_byte
  task do_reset();
    @(posedge clk) #1 rst_b = 1'b0;
    rf = '{8'hEE, 8'h02, 8'h2B, 0};
    repeat (6) @(posedge clk);
    #1 rst_b = 1'b1;
  endtask : do_reset
  task wr(logic [7:0] a, logic [7:0] d);
    host.wr(a, d);
    // only the documented bits of the mode byte are kept
    if (a >= 8'h68 && a <= 8'h6A) rf[a - 8'h68] = a == 8'h69 ? d & 8'h1B : d;
  endtask : wr
  task check_all();
    for (int i = 0; i < 5; i++) begin
      host.rd(i < 4 ? 8'h68 + 8'(i) : 8'h30, got);
      chk_byte(got, i < 4 ? 8'(rf[i]) : 8'h00);
    end
    e = rf[1][0] ? {rf[2][7:0], 1'(rf[2][7:6] == 3)} : {auto_vco_sel, auto_lock_value, 1'b0};
    x = {rf[1][4], rf[1][3], rf[1][0], rf[1][1] ? 5'h10 : 5'h14};
    chk_pins(32'({pump, res, cap, pole}), 32'(rf[0][7:0]));
    chk_pins(32'({tdc, syn, ovr, cnt}), 32'(x));
    chk_pins(32'({vco_sel, lock_value, rsvd}), 32'(e));
  endtask : check_all
  initial begin
    void'($urandom(32'hebcb2a26));
    do_reset();
    check_all();
    // first half automatic lock, second half manual with every oscillator code
    for (int i = 0; i < 16; i++) begin
      auto_vco_sel = 3'($urandom);
      auto_lock_value = 5'($urandom);
      wr(8'h68, {i[2:0], 5'($urandom)});
      wr(8'h69, (8'($urandom) & 8'h1A) | 8'(i[3]));
      wr(8'h6A, {i[2:0], 5'($urandom)});
      wr(8'h6B, 8'($urandom));
      wr(8'($urandom) & 8'h3F, 8'($urandom));
      check_all();
    end
    do_reset();
    check_all();
    report_and_stop();
  end
endmodule : tb
